/* File: design/tap_access_port.sv */
/*
 * Test access port into the two-way main translation buffer and the lockdown
 * buffer: entry select register, per-buffer staging registers, transfer
 * into the buffer rams, readback of the staged words.
 * Assumes the core issues at most one coprocessor operation per cycle on the
 * same clock and that both rams sit outside this block.
 */
// Contract
// - write entry select first; bit 31 picks way, other non-index bits zero
// - main buffer index comes from entry select bits 14 to 10
// - tag word: address 31:10, zero 9:5, valid bit 4, size 3:0
// - size codes 1011, 0111, 0101, 0011, 0001 mean 1M, 64K, 16K, 4K, 1K
// - translation word: address 31:10, zero 9:8, domain 7:4, rights 3:2, C, B
// - rights 00 none, 01 privileged, 10 adds user read, 11 all
// - write with opcode1 4 or 5 and crm 3 loads the tag staging
// - write with crm 5 loads the translation staging
// - write with crm 7 moves staging into ram at selected way and index
// - read crm 2 returns tag staging, crm 4 translation staging
// - opcode2 value 1 targets the lockdown buffer for every operation except entry select, which needs opcode2 0
// - main ram word is 112 bits, both ways per index
// - way 1 fields occupy the upper 56 bits of the write word
// - way 0 fields occupy the lower 56 bits of the write word
// - transfer replicates the entry onto both halves
// - only the selected way's lanes are enabled
// - ram writes on the edge with select high; four lane enables
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_access_port #(
	parameter int MAIN_IDX_W = 5,
	parameter int LOCK_IDX_W = 3
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  cp_valid,
	input  wire logic                  cp_write,
	input  wire logic [2:0]            cp_opc1,
	input  wire logic [3:0]            cp_crn,
	input  wire logic [3:0]            cp_crm,
	input  wire logic [2:0]            cp_opc2,
	input  wire logic [31:0]           cp_wdata,
	output logic [31:0]                cp_rdata,
	output logic                       cp_rvalid,
	output logic                       cp_done,
	output logic                       tlb_ram_select,
	output logic [3:0]                 tlb_ram_lane_wr,
	output logic [MAIN_IDX_W-1:0]      tlb_ram_index,
	output logic [111:0]               tlb_ram_wdata,
	output logic                       lock_ram_select,
	output logic [LOCK_IDX_W-1:0]      lock_ram_index,
	output logic [55:0]                lock_ram_wdata,
	output logic                       size_code_legal
);
	import tap_pkg::*;

	tap_op_t        op;
	logic           op_lock;
	logic [31:0]    op_wdata;
	logic [31:0]    tlb_entry_select_reg;
	logic [31:0]    main_tag;
	logic [31:0]    main_perm;
	logic [31:0]    lock_tag;
	logic [31:0]    lock_perm;

	function automatic logic size_known(input logic [3:0] code);
		case (code)
			TAP_SIZE_1M, TAP_SIZE_64K, TAP_SIZE_16K, TAP_SIZE_4K, TAP_SIZE_1K: size_known = 1'b1;
			default: size_known = 1'b0;
		endcase
	endfunction : size_known

	function automatic logic [55:0] pack_entry(input logic [31:0] tag, input logic [31:0] perm);
		tap_access_rights_t rights;
		rights = tap_access_rights_t'(
			perm[`TAP_PERM_ACCESS_RIGHTS_HI:`TAP_PERM_ACCESS_RIGHTS_LO]);
		pack_entry = {tag[`TAP_TAG_MODIFIED_VIRT_ADDR_HI:`TAP_TAG_MODIFIED_VIRT_ADDR_LO],
		              tag[`TAP_TAG_SIZE_HI:`TAP_TAG_SIZE_LO],
		              perm[`TAP_PERM_PHYSICAL_ADDR_HI:`TAP_PERM_PHYSICAL_ADDR_LO],
		              perm[`TAP_PERM_DOM_HI:`TAP_PERM_DOM_LO],
		              rights,
		              perm[`TAP_PERM_C_BIT],
		              perm[`TAP_PERM_B_BIT]};
	endfunction : pack_entry

	tap_cp_decode u_decode (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.cp_valid (cp_valid),
		.cp_write (cp_write),
		.cp_opc1  (cp_opc1),
		.cp_crn   (cp_crn),
		.cp_crm   (cp_crm),
		.cp_opc2  (cp_opc2),
		.cp_wdata (cp_wdata),
		.op       (op),
		.op_lock  (op_lock),
		.op_wdata (op_wdata)
	);

	wire main_tag_load  = op == TAP_OP_TAG_WR  && !op_lock;
	wire main_perm_load = op == TAP_OP_PERM_WR && !op_lock;
	wire lock_tag_load  = op == TAP_OP_TAG_WR  && op_lock;
	wire lock_perm_load = op == TAP_OP_PERM_WR && op_lock;

	tap_stage u_main_stage (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.tag_load  (main_tag_load),
		.perm_load (main_perm_load),
		.load_data (op_wdata),
		.tag_reg   (main_tag),
		.perm_reg  (main_perm)
	);

	tap_stage u_lock_stage (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.tag_load  (lock_tag_load),
		.perm_load (lock_perm_load),
		.load_data (op_wdata),
		.tag_reg   (lock_tag),
		.perm_reg  (lock_perm)
	);

	// only way, main index and lockdown index are kept
	wire [31:0] select_next = op_wdata & ({32{1'b0}}
	                        | (32'h1 << `TAP_SEL_WAY_BIT)
	                        | 32'h0000_7c00
	                        | 32'h1c00_0000);
	wire        sel_way     = tlb_entry_select_reg[`TAP_SEL_WAY_BIT];
	wire [MAIN_IDX_W-1:0] main_idx =
		MAIN_IDX_W'(tlb_entry_select_reg[`TAP_SEL_IDX_HI:`TAP_SEL_IDX_LO]);
	wire [LOCK_IDX_W-1:0] lock_idx =
		LOCK_IDX_W'(tlb_entry_select_reg[`TAP_SEL_LIDX_HI:`TAP_SEL_LIDX_LO]);

	wire        xfer_main  = op == TAP_OP_XFER && !op_lock;
	wire        xfer_lock  = op == TAP_OP_XFER && op_lock;
	wire [55:0] main_entry = pack_entry(main_tag, main_perm);
	wire [3:0]  way_lanes  = sel_way ? `TAP_LANES_WAY1 : `TAP_LANES_WAY0;

	wire [31:0] tag_rd  = op_lock ? lock_tag  : main_tag;
	wire [31:0] perm_rd = op_lock ? lock_perm : main_perm;
	wire        is_rd   = op == TAP_OP_TAG_RD || op == TAP_OP_PERM_RD || op == TAP_OP_SEL_RD;
	wire [31:0] rd_mux  = op == TAP_OP_TAG_RD  ? tag_rd :
	                      op == TAP_OP_PERM_RD ? perm_rd : tlb_entry_select_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tlb_entry_select_reg <= `TAP_SELECT_RESET;
		end else if (op == TAP_OP_SEL_WR) begin
			tlb_entry_select_reg <= select_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cp_rdata  <= 32'h0000_0000;
			cp_rvalid <= 1'b0;
			cp_done   <= 1'b0;
		end else begin
			cp_rvalid <= is_rd;
			cp_done   <= op != TAP_OP_NONE;
			// read data held until the next read
			if (is_rd) begin
				cp_rdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tlb_ram_select  <= 1'b0;
			tlb_ram_lane_wr <= 4'h0;
			tlb_ram_index   <= '0;
			tlb_ram_wdata   <= 112'h0;
		end else begin
			tlb_ram_select  <= xfer_main;
			tlb_ram_lane_wr <= xfer_main ? way_lanes : 4'h0;
			if (xfer_main) begin
				tlb_ram_index <= main_idx;
				tlb_ram_wdata <= {main_entry, main_entry};
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lock_ram_select <= 1'b0;
			lock_ram_index  <= '0;
			lock_ram_wdata  <= 56'h0;
		end else begin
			lock_ram_select <= xfer_lock;
			if (xfer_lock) begin
				lock_ram_index <= lock_idx;
				lock_ram_wdata <= pack_entry(lock_tag, lock_perm);
			end
		end
	end

	// legality of the staged main size
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			size_code_legal <= 1'b0;
		end else begin
			size_code_legal <= size_known(main_tag[`TAP_TAG_SIZE_HI:`TAP_TAG_SIZE_LO]);
		end
	end

endmodule : tap_access_port

`default_nettype wire

/* File: design/tap_cp_decode.sv */
/*
 * Registered decoder of one coprocessor operation into a one-hot op code,
 * the buffer it targets and its write data.
 * Assumes the request fields are valid in the cycle cp_valid is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_cp_decode (
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic          cp_valid,
	input  wire logic          cp_write,
	input  wire logic [2:0]    cp_opc1,
	input  wire logic [3:0]    cp_crn,
	input  wire logic [3:0]    cp_crm,
	input  wire logic [2:0]    cp_opc2,
	input  wire logic [31:0]   cp_wdata,
	output tap_pkg::tap_op_t   op,
	output logic               op_lock,
	output logic [31:0]        op_wdata
);
	import tap_pkg::*;

	wire       is_sel  = cp_crn == `TAP_CRN_TEST && cp_opc1 == `TAP_OPC1_SELECT
	                  && cp_crm == `TAP_CRM_SELECT && cp_opc2 == 3'h0;
	// both opcode1 values reach the same test operations
	wire       is_test = cp_crn == `TAP_CRN_TEST
	                  && (cp_opc1 == `TAP_OPC1_TEST_A || cp_opc1 == `TAP_OPC1_TEST_B)
	                  && (cp_opc2 == `TAP_OPC2_MAIN || cp_opc2 == `TAP_OPC2_LOCK);
	tap_op_t   op_next;

	always_comb begin
		op_next = TAP_OP_NONE;
		if (cp_valid && is_sel) begin
			op_next = cp_write ? TAP_OP_SEL_WR : TAP_OP_SEL_RD;
		end else if (cp_valid && is_test) begin
			case ({cp_write, cp_crm})
				{1'b0, `TAP_CRM_TAG_RD}:  op_next = TAP_OP_TAG_RD;
				{1'b0, `TAP_CRM_PERM_RD}: op_next = TAP_OP_PERM_RD;
				{1'b1, `TAP_CRM_TAG_WR}:  op_next = TAP_OP_TAG_WR;
				{1'b1, `TAP_CRM_PERM_WR}: op_next = TAP_OP_PERM_WR;
				{1'b1, `TAP_CRM_XFER}:    op_next = TAP_OP_XFER;
				default:                  op_next = TAP_OP_NONE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			op       <= TAP_OP_NONE;
			op_lock  <= 1'b0;
			op_wdata <= 32'h0000_0000;
		end else begin
			op       <= op_next;
			op_lock  <= cp_opc2 == `TAP_OPC2_LOCK;
			op_wdata <= cp_wdata;
		end
	end

endmodule : tap_cp_decode

`default_nettype wire

/* File: design/tap_pkg.sv */
/*
 * Types of the test access port: size codes, access rights, decoded operations.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package tap_pkg;

	typedef enum logic [3:0] {
		TAP_SIZE_1M   = 4'hb,
		TAP_SIZE_64K  = 4'h7,
		TAP_SIZE_16K  = 4'h5,
		TAP_SIZE_4K   = 4'h3,
		TAP_SIZE_1K   = 4'h1
	} tap_size_t;

	typedef enum logic [1:0] {
		TAP_RIGHTS_NONE    = 2'h0,
		TAP_RIGHTS_PRIV_RW = 2'h1,
		TAP_RIGHTS_USER_RO = 2'h2,
		TAP_RIGHTS_ALL_RW  = 2'h3
	} tap_access_rights_t;

	typedef enum logic [7:0] {
		TAP_OP_NONE    = 8'h01,
		TAP_OP_SEL_WR  = 8'h02,
		TAP_OP_SEL_RD  = 8'h04,
		TAP_OP_TAG_WR  = 8'h08,
		TAP_OP_TAG_RD  = 8'h10,
		TAP_OP_PERM_WR = 8'h20,
		TAP_OP_PERM_RD = 8'h40,
		TAP_OP_XFER    = 8'h80
	} tap_op_t;

endpackage : tap_pkg

`default_nettype wire

/* File: design/tap_regs.svh */
/*
 * Constants of the test access port into the translation buffers:
 * coprocessor operation codes, field positions, encodings and reset values.
 * Assumes a single includer scope; definitions only.
 */
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// coprocessor addressing
`define TAP_CRN_TEST       4'hf
`define TAP_OPC1_SELECT    3'h0
`define TAP_OPC1_TEST_A    3'h4
`define TAP_OPC1_TEST_B    3'h5
`define TAP_CRM_SELECT     4'h1
`define TAP_CRM_TAG_RD     4'h2
`define TAP_CRM_TAG_WR     4'h3
`define TAP_CRM_PERM_RD    4'h4
`define TAP_CRM_PERM_WR    4'h5
`define TAP_CRM_XFER       4'h7
`define TAP_OPC2_MAIN      3'h0
`define TAP_OPC2_LOCK      3'h1

// entry select word
`define TAP_SEL_WAY_BIT    31
`define TAP_SEL_IDX_HI     14
`define TAP_SEL_IDX_LO     10
`define TAP_SEL_LIDX_HI    28
`define TAP_SEL_LIDX_LO    26

// tag staging word
`define TAP_TAG_MODIFIED_VIRT_ADDR_HI 31
`define TAP_TAG_MODIFIED_VIRT_ADDR_LO 10
`define TAP_TAG_VALID_BIT  4
`define TAP_TAG_SIZE_HI    3
`define TAP_TAG_SIZE_LO    0
`define TAP_TAG_KEEP_MASK  32'hffff_fc1f

// translation staging word
`define TAP_PERM_PHYSICAL_ADDR_HI 31
`define TAP_PERM_PHYSICAL_ADDR_LO 10
`define TAP_PERM_DOM_HI    7
`define TAP_PERM_DOM_LO    4
`define TAP_PERM_ACCESS_RIGHTS_HI 3
`define TAP_PERM_ACCESS_RIGHTS_LO 2
`define TAP_PERM_C_BIT     1
`define TAP_PERM_B_BIT     0
`define TAP_PERM_KEEP_MASK 32'hffff_fcff

// ram lanes per way
`define TAP_LANES_WAY0     4'h3
`define TAP_LANES_WAY1     4'hc

// reset values
`define TAP_SELECT_RESET   32'h0000_0000
`define TAP_STAGE_RESET    32'h0000_0000

`endif

/* File: design/tap_stage.sv */
/*
 * Pair of staging registers (tag word and translation word) for one buffer.
 * Assumes load strobes are one-cycle pulses from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_stage (
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic          tag_load,
	input  wire logic          perm_load,
	input  wire logic [31:0]   load_data,
	output logic [31:0]        tag_reg,
	output logic [31:0]        perm_reg
);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tag_reg  <= `TAP_STAGE_RESET;
			perm_reg <= `TAP_STAGE_RESET;
		end else begin
			if (tag_load) begin
				tag_reg <= load_data & `TAP_TAG_KEEP_MASK;
			end
			if (perm_load) begin
				perm_reg <= load_data & `TAP_PERM_KEEP_MASK;
			end
		end
	end

endmodule : tap_stage

`default_nettype wire

/* File: testbench/tap_access_checker.sv */
/*
 * Checker of the translation buffer test access port, bound to its top module.
 * Assumes the two-cycle operation latency of the design and zero reset values.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_access_checker #(
	parameter int MAIN_IDX_W = 5,
	parameter int LOCK_IDX_W = 3
) (
	input wire logic                  sys_clk,
	input wire logic                  rst_n,
	input wire logic                  cp_valid,
	input wire logic                  cp_write,
	input wire logic [2:0]            cp_opc1,
	input wire logic [3:0]            cp_crn,
	input wire logic [3:0]            cp_crm,
	input wire logic [2:0]            cp_opc2,
	input wire logic [31:0]           cp_wdata,
	input wire logic [31:0]           cp_rdata,
	input wire logic                  cp_rvalid,
	input wire logic                  cp_done,
	input wire logic                  tlb_ram_select,
	input wire logic [3:0]            tlb_ram_lane_wr,
	input wire logic [MAIN_IDX_W-1:0] tlb_ram_index,
	input wire logic [111:0]          tlb_ram_wdata,
	input wire logic                  lock_ram_select,
	input wire logic [LOCK_IDX_W-1:0] lock_ram_index,
	input wire logic [55:0]           lock_ram_wdata,
	input wire logic                  size_code_legal
);
	wire cf = cp_valid && cp_crn == `TAP_CRN_TEST;
	wire t  = cf && (cp_opc1 == `TAP_OPC1_TEST_A || cp_opc1 == `TAP_OPC1_TEST_B);
	wire sl = cf && cp_opc1 == 3'h0 && cp_crm == `TAP_CRM_SELECT && cp_opc2 == 3'h0;
	wire m  = t && cp_opc2 == `TAP_OPC2_MAIN;
	wire xm = m && cp_write && cp_crm == `TAP_CRM_XFER;
	wire xl = t && cp_opc2 == `TAP_OPC2_LOCK && cp_write && cp_crm == `TAP_CRM_XFER;
	wire tr = m && !cp_write && cp_crm == `TAP_CRM_TAG_RD;
	wire wc = cp_crm == 4'h3 || cp_crm == 4'h5 || cp_crm == 4'h7;
	wire rc = cp_crm == 4'h2 || cp_crm == 4'h4;
	wire any = sl || (t && cp_opc2 < 3'h2 && (cp_write ? wc : rc));
	logic        way_reg;
	logic [4:0]  idx_reg;
	logic [31:0] tag_reg, perm_reg;
	wire [55:0]  ent = {tag_reg[31:10], tag_reg[3:0], perm_reg[31:10], perm_reg[7:0]};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			way_reg <= 1'b0;
			idx_reg <= 5'h00;
			tag_reg <= 32'h0;
			perm_reg <= 32'h0;
		end else begin
			if (sl && cp_write) {way_reg, idx_reg} <= {cp_wdata[31], cp_wdata[14:10]};
			if (m && cp_write && cp_crm == 4'h3) tag_reg <= cp_wdata & `TAP_TAG_KEEP_MASK;
			if (m && cp_write && cp_crm == 4'h5) perm_reg <= cp_wdata & `TAP_PERM_KEEP_MASK;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	xfer_select_a: assert property (xm |-> ##2 tlb_ram_select)
		else $error("main transfer gave no ram select");
	select_cause_a: assert property (tlb_ram_select |-> $past(xm, 2))
		else $error("ram select without transfer");
	lane_way_a: assert property (tlb_ram_select |->
		tlb_ram_lane_wr == ($past(way_reg, 2) ? `TAP_LANES_WAY1 : `TAP_LANES_WAY0))
		else $error("wrong lanes for way");
	lanes_idle_a: assert property (!tlb_ram_select |-> tlb_ram_lane_wr == 4'h0)
		else $error("lanes set without select");
	ram_index_a: assert property (tlb_ram_select |-> tlb_ram_index == $past(idx_reg, 2))
		else $error("wrong ram index");
	halves_copy_a: assert property (tlb_ram_select |-> tlb_ram_wdata[111:56] == tlb_ram_wdata[55:0])
		else $error("halves differ");
	entry_pack_a: assert property (tlb_ram_select |-> tlb_ram_wdata[55:0] == $past(ent, 2))
		else $error("wrong entry packing");
	tag_read_a: assert property ($past(tr, 2) |-> cp_rvalid && cp_rdata == $past(tag_reg, 2))
		else $error("wrong tag readback");
	lock_xfer_a: assert property (xl |-> ##2 lock_ram_select)
		else $error("lockdown transfer lost");
	done_cause_a: assert property (cp_done |-> $past(any, 2))
		else $error("done without accepted op");

	cover property (xm ##2 tlb_ram_select);
	cover property (xl ##2 lock_ram_select);
	cover property (tr ##2 cp_rvalid);
endmodule : tap_access_checker

bind tap_access_port tap_access_checker #(.MAIN_IDX_W(MAIN_IDX_W), .LOCK_IDX_W(LOCK_IDX_W)) i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .cp_valid(cp_valid), .cp_write(cp_write),
	.cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
	.cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid), .cp_done(cp_done),
	.tlb_ram_select(tlb_ram_select), .tlb_ram_lane_wr(tlb_ram_lane_wr),
	.tlb_ram_index(tlb_ram_index), .tlb_ram_wdata(tlb_ram_wdata),
	.lock_ram_select(lock_ram_select), .lock_ram_index(lock_ram_index),
	.lock_ram_wdata(lock_ram_wdata), .size_code_legal(size_code_legal));
`default_nettype wire

/* File: testbench/tap_ram_model.sv */
/*
 * Main buffer data ram model, written lane by lane.
 * Assumes select and lanes come from the port on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tap_ram_model (
	input wire logic         sys_clk,
	input wire logic         tlb_ram_select,
	input wire logic [3:0]   tlb_ram_lane_wr,
	input wire logic [4:0]   tlb_ram_index,
	input wire logic [111:0] tlb_ram_wdata
);
	logic [111:0] mem [32];

	initial for (int i = 0; i < 32; i++) mem[i] = 112'h0;

	// lane map kept literally, bit 56 in no lane
	always @(posedge sys_clk) begin
		if (tlb_ram_select) begin
			if (tlb_ram_lane_wr[0]) mem[tlb_ram_index][29:0] <= tlb_ram_wdata[29:0];
			if (tlb_ram_lane_wr[1]) mem[tlb_ram_index][55:30] <= tlb_ram_wdata[55:30];
			if (tlb_ram_lane_wr[2]) mem[tlb_ram_index][85:57] <= tlb_ram_wdata[85:57];
			if (tlb_ram_lane_wr[3]) mem[tlb_ram_index][111:86] <= tlb_ram_wdata[111:86];
		end
	end
endmodule : tap_ram_model
`default_nettype wire

/* File: testbench/testbench.sv */
/*
 * Self-checking bench of the test access port with a main ram model.
 * Assumes the two-cycle op latency and zero reset values of the port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module testbench;
	logic sys_clk = 0, rst_n = 0, cp_valid = 0, cp_write = 0, way = 0;
	logic [2:0] cp_opc1 = 0, cp_opc2 = 0, lock_ram_index;
	logic [3:0] cp_crn = 0, cp_crm = 0, tlb_ram_lane_wr;
	logic [31:0] cp_wdata = 0, cp_rdata, d, tg[2], pm[2];
	logic cp_rvalid, cp_done, tlb_ram_select, lock_ram_select, size_code_legal;
	logic [4:0] tlb_ram_index, idx = 0;
	logic [111:0] tlb_ram_wdata;
	logic [55:0] lock_ram_wdata, e[5];
	logic [127:0] rd_q[$], wr_q[$];
	logic [3:0] sizes[5] = '{4'hb, 4'h7, 4'h5, 4'h3, 4'h1};
	int error_cnt = 0, num_checks = 0, done_exp = 0, done_seen = 0;

	initial forever #2.5 sys_clk = ~sys_clk;

	tap_access_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cp_valid(cp_valid),
		.cp_write(cp_write), .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm),
		.cp_opc2(cp_opc2), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid),
		.cp_done(cp_done), .tlb_ram_select(tlb_ram_select), .tlb_ram_lane_wr(tlb_ram_lane_wr),
		.tlb_ram_index(tlb_ram_index), .tlb_ram_wdata(tlb_ram_wdata),
		.lock_ram_select(lock_ram_select), .lock_ram_index(lock_ram_index),
		.lock_ram_wdata(lock_ram_wdata), .size_code_legal(size_code_legal));
	tap_ram_model i_ram (.sys_clk(sys_clk), .tlb_ram_select(tlb_ram_select),
		.tlb_ram_lane_wr(tlb_ram_lane_wr), .tlb_ram_index(tlb_ram_index),
		.tlb_ram_wdata(tlb_ram_wdata));

	function automatic logic [55:0] entry(input int b);
		return {tg[b][31:10], tg[b][3:0], pm[b][31:10], pm[b][7:0]};
	endfunction : entry

	task automatic chk(input logic [127:0] s, input logic [127:0] x);
		num_checks++;
		if (s !== x) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	task automatic op(input logic w, input logic [2:0] o1, input logic [3:0] crn,
		input logic [3:0] crm, input logic [2:0] o2, input logic [31:0] v);
		cp_valid <= 1'b1;
		{cp_write, cp_opc1, cp_crn, cp_crm, cp_opc2, cp_wdata} <= {w, o1, crn, crm, o2, v};
		if (crn == `TAP_CRN_TEST && o2 < 3'h2) done_exp++;
		@(posedge sys_clk);
	endtask : op

	task automatic wr(input logic [3:0] crm, input logic [2:0] o2, input logic [31:0] v);
		op(1'b1, 3'h4 + 3'($urandom_range(1)), 4'hf, crm, o2, v);
		if (crm == 4'h3) tg[o2] = v & `TAP_TAG_KEEP_MASK;
		if (crm == 4'h5) pm[o2] = v & `TAP_PERM_KEEP_MASK;
		if (crm == 4'h7 && o2 == 3'h0)
			wr_q.push_back({way ? `TAP_LANES_WAY1 : `TAP_LANES_WAY0, idx, entry(0), entry(0)});
		if (crm == 4'h7 && o2 == 3'h1) wr_q.push_back({3'h0, entry(1)});
	endtask : wr

	task automatic rd(input logic [3:0] crm, input logic [2:0] o2);
		op(1'b0, 3'h4 + 3'($urandom_range(1)), 4'hf, crm, o2, 32'h0);
		rd_q.push_back(crm == 4'h2 ? tg[o2] : pm[o2]);
	endtask : rd

	task automatic wrap_up;
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	always @(negedge sys_clk) begin
		if (rst_n) begin
			if (cp_done === 1'b1) done_seen++;
			if (cp_rvalid === 1'b1) chk(cp_rdata, rd_q.pop_front());
			if (tlb_ram_select === 1'b1)
				chk({tlb_ram_lane_wr, tlb_ram_index, tlb_ram_wdata}, wr_q.pop_front());
			if (lock_ram_select === 1'b1) chk({lock_ram_index, lock_ram_wdata}, wr_q.pop_front());
		end
	end

	initial begin
		d = $urandom(59);
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		// back-to-back entry writes over every size and rights code
		for (int k = 0; k < 5; k++) begin
			way = k[0];
			idx = k > 2 ? 5'h07 : 5'($urandom);
			op(1'b1, 3'h0, 4'hf, 4'h1, 3'h0, {way, 16'h0, idx, 10'h0});
			d = $urandom;
			wr(4'h3, 3'h0, {d[31:4], sizes[k]});
			d = $urandom;
			wr(4'h5, 3'h0, {d[31:4], 2'(k), d[1:0]});
			wr(4'h7, 3'h0, 32'h0);
			e[k] = entry(0);
			rd(4'h2, 3'h0);
			rd(4'h4, 3'h0);
			chk(size_code_legal, 1'b1);
		end
		wr(4'h3, 3'h1, $urandom);
		wr(4'h5, 3'h1, $urandom);
		wr(4'h7, 3'h1, 32'h0);
		rd(4'h2, 3'h1);
		rd(4'h4, 3'h1);
		rd(4'h2, 3'h0);
		// foreign coprocessor space must leave the staging untouched
		op(1'b1, 3'h4, 4'he, 4'h3, 3'h0, 32'hffff_ffff);
		// opcode2 beyond the two buffers is refused, no done
		op(1'b1, 3'h4, 4'hf, 4'h3, 3'h2, 32'hffff_ffff);
		rd(4'h2, 3'h0);
		op(1'b0, 3'h0, 4'hf, 4'h1, 3'h0, 32'h0);
		rd_q.push_back({way, 16'h0, idx, 10'h0});
		d = $urandom;
		wr(4'h3, 3'h0, {d[31:4], 4'h2});
		cp_valid <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk(size_code_legal, 1'b0);
		chk(i_ram.mem[7], {e[3][55:1], 1'b0, e[4]});
		chk(done_seen, done_exp);
		chk(rd_q.size() + wr_q.size(), 0);
		wrap_up();
	end

	initial begin
		#5000;
		error_cnt++;
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
